// ---- bench/tb_bias_and_system_control_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_bias_and_system_control_regs;
  // ----------------------------------------------------------------
  // signals and dut
  // ----------------------------------------------------------------
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  bias_sys_pkg::bias_ctrl_t bias_ctrl;
  bias_sys_pkg::monitor_ctrl_t monitor_ctrl;
  logic [4:0] calibration_sample_count;
  logic timeout_enable, crc_enable, status_byte_enable;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  logic [7:0] v, got;
  bias_and_system_control_regs dut (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .bias_ctrl(bias_ctrl), .monitor_ctrl(monitor_ctrl),
    .calibration_sample_count(calibration_sample_count), .timeout_enable(timeout_enable),
    .crc_enable(crc_enable), .status_byte_enable(status_byte_enable));
  initial begin
    forever #2.5 clock = ~clock;
  end
  // ----------------------------------------------------------------
  // expectations, checks and bus tasks
  // ----------------------------------------------------------------
  function automatic logic [7:0] mon_exp(input logic [2:0] c);
    // order: mux_open, gain_one, temp, mid_short, asupply, dsupply, burnout, burnout_high
    case (c)
      3'h1: mon_exp = 8'h90;
      3'h2: mon_exp = 8'ha0;
      3'h3: mon_exp = 8'hc8;
      3'h4: mon_exp = 8'hc4;
      3'h5: mon_exp = 8'h02;
      3'h6: mon_exp = 8'h03;
      default: mon_exp = 8'h00;
    endcase
  endfunction
  function automatic logic [4:0] cal_exp(input logic [1:0] c);
    cal_exp = (c == 2'h0) ? 5'h01 : (c == 2'h1) ? 5'h04 : (c == 2'h2) ? 5'h08 : 5'h10;
  endfunction
  task automatic chk(input logic [15:0] g, input logic [15:0] e, input string what);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, g, e);
    end
  endtask
  task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
    #1;
  endtask
  task automatic bus_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic chk_sys(input logic [7:0] s);
    logic [7:0] r;
    chk(monitor_ctrl, mon_exp(s[7:5]), "monitor");
    chk(calibration_sample_count, cal_exp(s[4:3]), "cal count");
    chk({timeout_enable, crc_enable, status_byte_enable}, s[2:0], "enables");
    bus_read(bias_sys_pkg::SYSCTL_ADDR, r);
    chk(r, s, "sysctl readback");
  endtask
  task automatic chk_bias(input logic [7:0] b);
    logic [7:0] r;
    chk(bias_ctrl, {|b[6:0], b[7], b[6:0]}, "bias ctrl");
    bus_read(bias_sys_pkg::BIAS_ADDR, r);
    chk(r, b, "bias readback");
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      complete_run();
    end
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(67));
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    #1;
    chk_sys(8'h10);
    chk_bias(8'h00);
    $display("test reset done");
    // amplifier enable and temperature gain limit stay with the host, outside this block
    for (int i = 0; i < 32; i++) begin
      v = (i < 8) ? {i[2:0], i[1:0], i[2:0]} : 8'($urandom);
      bus_write(bias_sys_pkg::SYSCTL_ADDR, v);
      chk_sys(v);
    end
    $display("test system control done");
    for (int i = 0; i < 24; i++) begin
      v = (i == 0) ? 8'h80 : (i == 1) ? 8'h7f : (i == 2) ? 8'hff : (i == 3) ? 8'h00 : 8'($urandom);
      bus_write(bias_sys_pkg::BIAS_ADDR, v);
      chk_bias(v);
    end
    $display("test bias done");
    bus_write(8'h0a, 8'hff);
    bus_read(8'h0a, got);
    chk(got, bias_sys_pkg::UNMAPPED_READ, "unmapped read");
    @(posedge clock);
    #1 chk(rdata, 8'h00, "rdata after read");
    chk_bias(v);
    $display("test unmapped done");
    @(posedge clock);
    wr <= 1'b1;
    addr <= bias_sys_pkg::SYSCTL_ADDR;
    wdata <= 8'h67;
    @(posedge clock);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 chk(rdata, 8'h67, "write then read");
    @(posedge clock);
    #1 chk(rdata, bias_sys_pkg::UNMAPPED_READ, "rdata stands one cycle");
    chk_sys(8'h67);
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    #1 chk_sys(8'h10);
    chk_bias(8'h00);
    $display("test back to back and reset done");
    complete_run();
  end
endmodule // tb_bias_and_system_control_regs
`default_nettype wire

// ---- hdl/bias_and_system_control_regs.sv ----
// Summary of operation
// - bias register bit 7 picks the bias level, 0 supply midpoint (reset), 1 one twelfth of the supply sum.
// - the bias generator is off whenever no bias input-select bit is set.
// - bias bits 6..0 each connect the bias to the common input or to inputs five to zero.
// - any combination of bias select bits is accepted and driven at once.
// - monitor code 000 off, 001 midpoint short, 011 analog supply/4, 100 digital supply/4.
// - monitor code 101 turns burn-out sources on at 0.2 uA, 110 at 10 uA.
// - either supply monitor code forces the amplifier gain to one.
// - midpoint-short, temperature and supply monitors open all input mux switches.
// - the calibration field picks 1, 4, 8 (reset) or 16 averaged samples.
// - system control bit 2 enables the serial timeout, off after reset.
// - system control bit 1 appends a CRC byte covering the result and the status byte if sent.
// - system control bit 0 prepends a status byte, off after reset.
// - the system control register resets to 10h.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module bias_and_system_control_regs (
  input wire logic clock,                                      // 200 MHz clock
  input wire logic rst,                                        // sync reset, active high
  input wire logic [bias_sys_pkg::ADDR_W-1:0] addr,            // register address
  input wire logic [bias_sys_pkg::DATA_W-1:0] wdata,           // write data
  input wire logic wr,                                         // write strobe
  input wire logic rd,                                         // read strobe
  output logic [bias_sys_pkg::DATA_W-1:0] rdata,               // read data, cycle after rd
  output bias_sys_pkg::bias_ctrl_t bias_ctrl,                  // bias generator controls
  output bias_sys_pkg::monitor_ctrl_t monitor_ctrl,            // system monitor controls
  output logic [4:0] calibration_sample_count,                 // samples averaged
  output logic timeout_enable,                                 // serial timeout on
  output logic crc_enable,                                     // append crc byte
  output logic status_byte_enable                              // prepend status byte
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  bias_sys_pkg::regs_state_t s_q;
  bias_sys_pkg::regs_state_t s_d;
  bias_sys_pkg::monitor_ctrl_t mon_dec;
  logic [bias_sys_pkg::MON_W-1:0] mon_code;
  logic [bias_sys_pkg::CAL_W-1:0] cal_field;
  logic [4:0] cal_count;
  logic bias_hit;
  logic sysctl_hit;
  logic unmapped_hit;

  always_comb begin
    s_d = s_q;
    s_d.rdata_q = bias_sys_pkg::UNMAPPED_READ;
    if (wr) begin
      if (addr == bias_sys_pkg::BIAS_ADDR) begin
        s_d.bias_q = wdata;
      end else if (addr == bias_sys_pkg::SYSCTL_ADDR) begin
        s_d.sysctl_q = wdata;
      end
    end
    if (rd) begin
      if (addr == bias_sys_pkg::BIAS_ADDR) begin
        s_d.rdata_q = s_q.bias_q;
      end else if (addr == bias_sys_pkg::SYSCTL_ADDR) begin
        s_d.rdata_q = s_q.sysctl_q;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_q.bias_q <= bias_sys_pkg::BIAS_RESET;
      s_q.sysctl_q <= bias_sys_pkg::SYSCTL_RESET;
      s_q.rdata_q <= bias_sys_pkg::UNMAPPED_READ;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rdata_q;

  // ----------------------------------------------------------------
  // bias outputs
  // ----------------------------------------------------------------
  always_comb begin
    bias_ctrl.bias_level_sel = s_q.bias_q[bias_sys_pkg::BIAS_LEVEL_BIT];
    bias_ctrl.bias_pins = s_q.bias_q[bias_sys_pkg::BIAS_PINS-1:0];
    bias_ctrl.bias_enable = |s_q.bias_q[bias_sys_pkg::BIAS_PINS-1:0];
  end

  // ----------------------------------------------------------------
  // system control outputs
  // ----------------------------------------------------------------
  assign mon_code = s_q.sysctl_q[bias_sys_pkg::MON_LSB +: bias_sys_pkg::MON_W];
  monitor_decode u_mon (
    .code(mon_code),
    .ctrl(mon_dec)
  );
  // temperature mode relies on the host having enabled the amplifier
  assign monitor_ctrl = mon_dec;

  assign cal_field = s_q.sysctl_q[bias_sys_pkg::CAL_LSB +: bias_sys_pkg::CAL_W];
  always_comb begin
    unique case (bias_sys_pkg::cal_samp_t'(cal_field))
      bias_sys_pkg::CAL_1: cal_count = bias_sys_pkg::CAL_COUNT_1;
      bias_sys_pkg::CAL_4: cal_count = bias_sys_pkg::CAL_COUNT_4;
      bias_sys_pkg::CAL_8: cal_count = bias_sys_pkg::CAL_COUNT_8;
      bias_sys_pkg::CAL_16: cal_count = bias_sys_pkg::CAL_COUNT_16;
    endcase
  end
  assign calibration_sample_count = cal_count;

  assign timeout_enable = s_q.sysctl_q[bias_sys_pkg::TIMEOUT_BIT];
  assign crc_enable = s_q.sysctl_q[bias_sys_pkg::CRC_BIT];
  assign status_byte_enable = s_q.sysctl_q[bias_sys_pkg::STATUS_BIT];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  assign bias_hit = addr == bias_sys_pkg::BIAS_ADDR;
  assign sysctl_hit = addr == bias_sys_pkg::SYSCTL_ADDR;
  assign unmapped_hit = !bias_hit && !sysctl_hit;

  AST_BIAS_OFF: assert property (@(posedge clock) disable iff (rst)
    (wr && bias_hit && wdata[bias_sys_pkg::BIAS_PINS-1:0] == '0) |=> !bias_ctrl.bias_enable)
    else $error("bias on with no input selected");
  AST_BIAS_LEVEL: assert property (@(posedge clock) disable iff (rst)
    (wr && addr == bias_sys_pkg::BIAS_ADDR) |=> bias_ctrl.bias_level_sel == $past(wdata[7]))
    else $error("bias level not from written bit");
  AST_BIAS_PINS: assert property (@(posedge clock) disable iff (rst)
    (wr && addr == bias_sys_pkg::BIAS_ADDR) |=> bias_ctrl.bias_pins == $past(wdata[6:0]))
    else $error("bias pins not from written bits");
  AST_MULTI: assert property (@(posedge clock) disable iff (rst)
    (wr && bias_hit && $countones(wdata[bias_sys_pkg::BIAS_PINS-1:0]) > 1) |=>
      bias_ctrl.bias_enable && bias_ctrl.bias_pins == $past(wdata[bias_sys_pkg::BIAS_PINS-1:0]))
    else $error("multiple bias inputs refused");
  AST_MON_MUX: assert property (@(posedge clock) disable iff (rst)
    (s_q.sysctl_q[7:5] inside {3'h1, 3'h2, 3'h3, 3'h4}) |-> monitor_ctrl.mux_open)
    else $error("mux not open in monitor mode");
  AST_GAIN: assert property (@(posedge clock) disable iff (rst)
    monitor_ctrl.gain_force_one == (s_q.sysctl_q[7:5] inside {3'h3, 3'h4}))
    else $error("gain force wrong");
  AST_BURN: assert property (@(posedge clock) disable iff (rst)
    monitor_ctrl.burnout_enable == (s_q.sysctl_q[7:5] inside {3'h5, 3'h6}) &&
    monitor_ctrl.burnout_high == (s_q.sysctl_q[7:5] == 3'h6))
    else $error("burn-out control wrong");
  AST_MON_OFF: assert property (@(posedge clock) disable iff (rst)
    (s_q.sysctl_q[7:5] inside {3'h0, 3'h7}) |-> monitor_ctrl == '0)
    else $error("monitor active when disabled");
  AST_CAL: assert property (@(posedge clock) disable iff (rst)
    calibration_sample_count == ((s_q.sysctl_q[4:3] == 2'h0) ? 5'h01 :
      (s_q.sysctl_q[4:3] == 2'h1) ? 5'h04 : (s_q.sysctl_q[4:3] == 2'h2) ? 5'h08 : 5'h10))
    else $error("calibration count wrong");
  AST_RESET: assert property (@(posedge clock)
    rst |=> s_q.sysctl_q == bias_sys_pkg::SYSCTL_RESET && !timeout_enable && !crc_enable && !status_byte_enable)
    else $error("system control reset value wrong");
  AST_FLAGS: assert property (@(posedge clock) disable iff (rst)
    (wr && addr == bias_sys_pkg::SYSCTL_ADDR) |=>
      {timeout_enable, crc_enable, status_byte_enable} == $past(wdata[2:0]))
    else $error("control flags not from written bits");
  AST_READBACK: assert property (@(posedge clock) disable iff (rst)
    (wr && addr == bias_sys_pkg::SYSCTL_ADDR) ##1 (rd && addr == bias_sys_pkg::SYSCTL_ADDR && !wr)
      |=> rdata == $past(wdata, 2))
    else $error("readback mismatch");

  // ----------------------------------------------------------------
  // reset checks
  // ----------------------------------------------------------------
  AST_BIAS_RESET: assert property (@(posedge clock)
    rst |=> bias_ctrl == '0)
    else $error("bias controls not cleared by reset");

  AST_MON_RESET: assert property (@(posedge clock)
    rst |=> monitor_ctrl == '0)
    else $error("monitor active after reset");

  AST_CAL_RESET: assert property (@(posedge clock)
    rst |=> calibration_sample_count == bias_sys_pkg::CAL_COUNT_8)
    else $error("calibration count not eight after reset");

  AST_TIMEOUT_RESET: assert property (@(posedge clock)
    rst |=> !timeout_enable)
    else $error("timeout enabled after reset");

  AST_CRC_RESET: assert property (@(posedge clock)
    rst |=> !crc_enable)
    else $error("crc enabled after reset");

  AST_STATUS_RESET: assert property (@(posedge clock)
    rst |=> !status_byte_enable)
    else $error("status byte enabled after reset");

  AST_RDATA_RESET: assert property (@(posedge clock)
    rst |=> rdata == bias_sys_pkg::UNMAPPED_READ)
    else $error("read data not cleared by reset");

  AST_BIAS_REG_RESET: assert property (@(posedge clock)
    rst |=> s_q.bias_q == bias_sys_pkg::BIAS_RESET)
    else $error("bias register reset value wrong");

  // ----------------------------------------------------------------
  // register bus checks
  // ----------------------------------------------------------------
  AST_WR_BIAS: assert property (@(posedge clock) disable iff (rst)
    (wr && bias_hit) |=> s_q.bias_q == $past(wdata))
    else $error("bias write not stored");

  AST_WR_SYSCTL: assert property (@(posedge clock) disable iff (rst)
    (wr && sysctl_hit) |=> s_q.sysctl_q == $past(wdata))
    else $error("system control write not stored");

  AST_WR_UNMAPPED: assert property (@(posedge clock) disable iff (rst)
    (wr && unmapped_hit) |=> $stable(s_q.bias_q) && $stable(s_q.sysctl_q))
    else $error("unmapped write changed a register");

  AST_HOLD: assert property (@(posedge clock) disable iff (rst)
    !wr |=> $stable(s_q.bias_q) && $stable(s_q.sysctl_q))
    else $error("register changed without a write");

  AST_WR_BIAS_KEEP_SYS: assert property (@(posedge clock) disable iff (rst)
    (wr && bias_hit) |=> $stable(s_q.sysctl_q))
    else $error("bias write changed system control");

  AST_WR_SYS_KEEP_BIAS: assert property (@(posedge clock) disable iff (rst)
    (wr && sysctl_hit) |=> $stable(bias_ctrl))
    else $error("system control write changed bias controls");

  AST_RD_BIAS: assert property (@(posedge clock) disable iff (rst)
    (rd && bias_hit) |=> rdata == $past(s_q.bias_q))
    else $error("bias read data wrong");

  AST_RD_SYSCTL: assert property (@(posedge clock) disable iff (rst)
    (rd && sysctl_hit) |=> rdata == $past(s_q.sysctl_q))
    else $error("system control read data wrong");

  AST_RD_UNMAPPED: assert property (@(posedge clock) disable iff (rst)
    (rd && unmapped_hit) |=> rdata == bias_sys_pkg::UNMAPPED_READ)
    else $error("unmapped read not zero");

  AST_RD_IDLE: assert property (@(posedge clock) disable iff (rst)
    !rd |=> rdata == bias_sys_pkg::UNMAPPED_READ)
    else $error("read data stands past its cycle");

  // ----------------------------------------------------------------
  // bias checks
  // ----------------------------------------------------------------
  AST_BIAS_ON: assert property (@(posedge clock) disable iff (rst)
    (wr && bias_hit && wdata[bias_sys_pkg::BIAS_PINS-1:0] != '0) |=> bias_ctrl.bias_enable)
    else $error("bias off with an input selected");

  AST_BIAS_LEVEL_LOW: assert property (@(posedge clock) disable iff (rst)
    (wr && bias_hit && !wdata[bias_sys_pkg::BIAS_LEVEL_BIT]) |=> !bias_ctrl.bias_level_sel)
    else $error("bias level not midpoint");

  // ----------------------------------------------------------------
  // system control checks
  // ----------------------------------------------------------------
  AST_TIMEOUT: assert property (@(posedge clock) disable iff (rst)
    (wr && sysctl_hit) |=> timeout_enable == $past(wdata[bias_sys_pkg::TIMEOUT_BIT]))
    else $error("timeout enable not from written bit");

  AST_CRC: assert property (@(posedge clock) disable iff (rst)
    (wr && sysctl_hit) |=> crc_enable == $past(wdata[bias_sys_pkg::CRC_BIT]))
    else $error("crc enable not from written bit");

  AST_STATUS: assert property (@(posedge clock) disable iff (rst)
    (wr && sysctl_hit) |=> status_byte_enable == $past(wdata[bias_sys_pkg::STATUS_BIT]))
    else $error("status byte enable not from written bit");

  AST_MID_SHORT: assert property (@(posedge clock) disable iff (rst)
    (mon_code == bias_sys_pkg::MON_MID_SHORT) |->
      monitor_ctrl.supply_short_mid && monitor_ctrl.mux_open && !monitor_ctrl.gain_force_one)
    else $error("midpoint short mode wrong");

  AST_TEMP: assert property (@(posedge clock) disable iff (rst)
    (mon_code == bias_sys_pkg::MON_TEMP) |->
      monitor_ctrl.temp_sensor_on && monitor_ctrl.mux_open && !monitor_ctrl.gain_force_one)
    else $error("temperature mode wrong");

  AST_ASUPPLY: assert property (@(posedge clock) disable iff (rst)
    (mon_code == bias_sys_pkg::MON_ASUPPLY) |-> monitor_ctrl.analog_supply_mon && !monitor_ctrl.digital_supply_mon)
    else $error("analog supply mode wrong");

  AST_DSUPPLY: assert property (@(posedge clock) disable iff (rst)
    (mon_code == bias_sys_pkg::MON_DSUPPLY) |-> monitor_ctrl.digital_supply_mon && !monitor_ctrl.analog_supply_mon)
    else $error("digital supply mode wrong");

  AST_BURN_LOW: assert property (@(posedge clock) disable iff (rst)
    (mon_code == bias_sys_pkg::MON_BURN_LOW) |->
      monitor_ctrl.burnout_enable && !monitor_ctrl.burnout_high && !monitor_ctrl.mux_open)
    else $error("low burn-out mode wrong");

  AST_BURN_HIGH: assert property (@(posedge clock) disable iff (rst)
    (mon_code == bias_sys_pkg::MON_BURN_HIGH) |->
      monitor_ctrl.burnout_enable && monitor_ctrl.burnout_high && !monitor_ctrl.mux_open)
    else $error("high burn-out mode wrong");

  AST_MUX_CLOSED: assert property (@(posedge clock) disable iff (rst)
    !(mon_code inside {bias_sys_pkg::MON_MID_SHORT, bias_sys_pkg::MON_TEMP, bias_sys_pkg::MON_ASUPPLY,
      bias_sys_pkg::MON_DSUPPLY}) |-> !monitor_ctrl.mux_open)
    else $error("mux opened outside monitor modes");

  AST_ONE_MEAS: assert property (@(posedge clock) disable iff (rst)
    $onehot0({monitor_ctrl.temp_sensor_on, monitor_ctrl.supply_short_mid, monitor_ctrl.analog_supply_mon,
      monitor_ctrl.digital_supply_mon, monitor_ctrl.burnout_enable}))
    else $error("more than one monitor function on");

  AST_UNDEF: assert property (@(posedge clock) disable iff (rst)
    (mon_code == bias_sys_pkg::MON_UNDEF) |-> monitor_ctrl == '0)
    else $error("undefined monitor code not disabled");

  AST_CAL_ONE: assert property (@(posedge clock) disable iff (rst)
    (wr && sysctl_hit && wdata[bias_sys_pkg::CAL_LSB +: bias_sys_pkg::CAL_W] == bias_sys_pkg::CAL_1) |=>
      calibration_sample_count == bias_sys_pkg::CAL_COUNT_1)
    else $error("calibration count not one");

  AST_CAL_FOUR: assert property (@(posedge clock) disable iff (rst)
    (wr && sysctl_hit && wdata[bias_sys_pkg::CAL_LSB +: bias_sys_pkg::CAL_W] == bias_sys_pkg::CAL_4) |=>
      calibration_sample_count == bias_sys_pkg::CAL_COUNT_4)
    else $error("calibration count not four");

  AST_CAL_EIGHT: assert property (@(posedge clock) disable iff (rst)
    (wr && sysctl_hit && wdata[bias_sys_pkg::CAL_LSB +: bias_sys_pkg::CAL_W] == bias_sys_pkg::CAL_8) |=>
      calibration_sample_count == bias_sys_pkg::CAL_COUNT_8)
    else $error("calibration count not eight");

  AST_CAL_SIXTEEN: assert property (@(posedge clock) disable iff (rst)
    (wr && sysctl_hit && wdata[bias_sys_pkg::CAL_LSB +: bias_sys_pkg::CAL_W] == bias_sys_pkg::CAL_16) |=>
      calibration_sample_count == bias_sys_pkg::CAL_COUNT_16)
    else $error("calibration count not sixteen");

endmodule // bias_and_system_control_regs
`default_nettype wire

// ---- hdl/bias_sys_pkg.sv ----
`default_nettype none
package bias_sys_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] BIAS_ADDR = 8'h08;
  localparam logic [7:0] SYSCTL_ADDR = 8'h09;
  localparam logic [7:0] BIAS_RESET = 8'h00;
  localparam logic [7:0] SYSCTL_RESET = 8'h10;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIAS_LEVEL_BIT = 7;
  localparam int BIAS_PINS = 7;
  localparam int MON_LSB = 5;
  localparam int CAL_LSB = 3;
  localparam int TIMEOUT_BIT = 2;
  localparam int CRC_BIT = 1;
  localparam int STATUS_BIT = 0;
  localparam int MON_W = 3;
  localparam int CAL_W = 2;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MON_OFF = 3'h0,
    MON_MID_SHORT = 3'h1,
    MON_TEMP = 3'h2,
    MON_ASUPPLY = 3'h3,
    MON_DSUPPLY = 3'h4,
    MON_BURN_LOW = 3'h5,
    MON_BURN_HIGH = 3'h6,
    MON_UNDEF = 3'h7
  } monitor_sel_t;

  typedef enum logic [1:0] {
    CAL_1 = 2'h0,
    CAL_4 = 2'h1,
    CAL_8 = 2'h2,
    CAL_16 = 2'h3
  } cal_samp_t;

  localparam logic [4:0] CAL_COUNT_1 = 5'h01;
  localparam logic [4:0] CAL_COUNT_4 = 5'h04;
  localparam logic [4:0] CAL_COUNT_8 = 5'h08;
  localparam logic [4:0] CAL_COUNT_16 = 5'h10;

  typedef struct packed {
    logic [7:0] bias_q;
    logic [7:0] sysctl_q;
    logic [7:0] rdata_q;
  } regs_state_t;

  typedef struct packed {
    logic bias_enable;
    logic bias_level_sel;
    logic [6:0] bias_pins;
  } bias_ctrl_t;

  typedef struct packed {
    logic mux_open;
    logic gain_force_one;
    logic temp_sensor_on;
    logic supply_short_mid;
    logic analog_supply_mon;
    logic digital_supply_mon;
    logic burnout_enable;
    logic burnout_high;
  } monitor_ctrl_t;

endpackage
`default_nettype wire

// ---- hdl/monitor_decode.sv ----
`timescale 1ns/1ps
`default_nettype none
module monitor_decode (
  input wire logic [2:0] code,                       // monitor select field
  output bias_sys_pkg::monitor_ctrl_t ctrl           // decoded controls
);
  always_comb begin
    ctrl = '0;
    unique case (bias_sys_pkg::monitor_sel_t'(code))
      bias_sys_pkg::MON_OFF: begin
        ctrl = '0;
      end
      bias_sys_pkg::MON_MID_SHORT: begin
        ctrl.supply_short_mid = 1'b1;
        ctrl.mux_open = 1'b1;
      end
      bias_sys_pkg::MON_TEMP: begin
        ctrl.temp_sensor_on = 1'b1;
        ctrl.mux_open = 1'b1;
      end
      bias_sys_pkg::MON_ASUPPLY: begin
        ctrl.analog_supply_mon = 1'b1;
        ctrl.gain_force_one = 1'b1;
        ctrl.mux_open = 1'b1;
      end
      bias_sys_pkg::MON_DSUPPLY: begin
        ctrl.digital_supply_mon = 1'b1;
        ctrl.gain_force_one = 1'b1;
        ctrl.mux_open = 1'b1;
      end
      bias_sys_pkg::MON_BURN_LOW: begin
        ctrl.burnout_enable = 1'b1;
      end
      bias_sys_pkg::MON_BURN_HIGH: begin
        ctrl.burnout_enable = 1'b1;
        ctrl.burnout_high = 1'b1;
      end
      bias_sys_pkg::MON_UNDEF: begin
        ctrl = '0;
      end
    endcase
  end
endmodule // monitor_decode
`default_nettype wire
